// >>> hdl/fr_pkg.sv
/*
 Constants, op codes and timing counts for the flash reset/program host controller.
 Assumes a 100 MHz clock and a byte-wide parallel flash with an active-low reset pin.
*/
package fr_pkg;

    localparam int ADDR_W          = 20;
    localparam int DATA_W          = 8;
    localparam int TMR_W           = 12;

    localparam int CLK_PERIOD_NS   = 10;
    localparam int T_WP_NS         = 50;
    localparam int T_WPH_NS        = 20;
    localparam int T_ACC_NS        = 150;
    localparam int T_RP_NS         = 500;
    localparam int T_READY_EMB_NS  = 20000;
    localparam int T_READY_NS      = 500;
    localparam int T_RH_NS         = 50;
    localparam int T_RSP_NS        = 4000;
    localparam int T_VIDR_NS       = 500;

    // Least times, rounded up to whole cycles
    localparam int WP_CYC          = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC         = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC         = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC          = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_EMB_CYC   = (T_READY_EMB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYC       = (T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC          = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RSP_CYC         = (T_RSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VIDR_CYC        = (T_VIDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wait after release: the rest of the ready time plus the high time before a read
    localparam int REL_EMB_CYC     = READY_EMB_CYC - RP_CYC + RH_CYC;
    localparam int REL_CYC         = READY_CYC - RP_CYC + RH_CYC;

    // Status bit positions
    localparam int BIT_BUSY_TOGGLE = 6;
    localparam int BIT_TIME_LIMIT  = 5;
    localparam int BIT_SUSP_TOGGLE = 2;

    // Last step index of each command sequence
    localparam logic [2:0] LAST_PROG  = 3'h3;
    localparam logic [2:0] LAST_ERASE = 3'h5;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_PROGRAM,
        OP_ERASE,
        OP_RESET,
        OP_STANDBY,
        OP_UNPROT_ON,
        OP_UNPROT_OFF
    } fr_op_t;

endpackage

// >>> hdl/fr_cycle.sv
/*
 One read or write bus cycle on the flash pins, strobed by output enable or write enable.
 Assumes the caller waits for done before the next start and that dq_i is synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module fr_cycle (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Request and answer
    input  wire logic                      start,
    input  wire logic                      wr,
    input  wire logic [fr_pkg::ADDR_W-1:0] addr,
    input  wire logic [fr_pkg::DATA_W-1:0] wdata,
    output logic                           done,
    output logic      [fr_pkg::DATA_W-1:0] rdata,
    // Flash pins
    output logic                           ce_n,
    output logic                           we_n,
    output logic                           oe_n,
    output logic      [fr_pkg::ADDR_W-1:0] addr_o,
    output logic      [fr_pkg::DATA_W-1:0] dq_o,
    output logic                           dq_oe_n,
    input  wire logic [fr_pkg::DATA_W-1:0] dq_i
);
    import fr_pkg::*;

    typedef enum {CY_IDLE, CY_SETUP, CY_STRB, CY_RECOV} fr_cy_state_t;

    fr_cy_state_t state_r;
    logic         wr_r;
    logic [4:0]   cnt_r;

    wire cnt_zero = (cnt_r == 5'h00);

    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (!reset_n) begin
            state_r <= CY_IDLE;
            wr_r    <= 1'b0;
            cnt_r   <= 5'h00;
            rdata   <= '0;
            ce_n    <= 1'b1;
            we_n    <= 1'b1;
            oe_n    <= 1'b1;
            addr_o  <= '0;
            dq_o    <= '0;
            dq_oe_n <= 1'b1;
        end else begin
            case (state_r)
                CY_IDLE: begin
                    if (start) begin
                        wr_r    <= wr;
                        addr_o  <= addr;
                        dq_o    <= wdata;
                        dq_oe_n <= !wr;
                        ce_n    <= 1'b0;
                        state_r <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    we_n    <= !wr_r;
                    oe_n    <= wr_r;
                    cnt_r   <= wr_r ? 5'(WP_CYC - 1) : 5'(ACC_CYC - 1);
                    state_r <= CY_STRB;
                end
                CY_STRB: begin
                    if (cnt_zero) begin
                        we_n    <= 1'b1;
                        oe_n    <= 1'b1;
                        if (!wr_r) begin
                            rdata <= dq_i;
                        end
                        cnt_r   <= 5'(WPH_CYC - 1);
                        state_r <= CY_RECOV;
                    end else begin
                        cnt_r <= cnt_r - 5'h01;
                    end
                end
                CY_RECOV: begin
                    // Data and address held through recovery, so data hold is never short
                    if (cnt_zero) begin
                        ce_n    <= 1'b1;
                        dq_oe_n <= 1'b1;
                        done    <= 1'b1;
                        state_r <= CY_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 5'h01;
                    end
                end
                default: state_r <= CY_IDLE;
            endcase
        end
    end

    a_we_width: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(we_n) |-> (!we_n)[*5])
        else $error("write pulse shorter than its minimum");

    a_oe_under_ce: assert property (@(posedge clk) disable iff (!reset_n)
        !oe_n |-> !ce_n && dq_oe_n)
        else $error("output enable without chip enable or with bus driven");

endmodule
`default_nettype wire

// >>> hdl/fr_ctrl.sv
/*
 Host controller that drives a parallel flash: reads, raw writes, byte program and
 sector erase with toggle-bit polling, hardware reset, standby and temporary unprotect.
 Assumes the flash pins are synchronous to clk and a board driver turns vid_en into the
 elevated reset level.
*/
`timescale 1ns/10ps
`default_nettype none
module fr_ctrl #(
    parameter logic [fr_pkg::ADDR_W-1:0] UNLK_ADDR1 = 20'h00555,
    parameter logic [fr_pkg::ADDR_W-1:0] UNLK_ADDR2 = 20'h002aa,
    parameter logic [fr_pkg::DATA_W-1:0] UNLK_DATA1 = 8'haa,
    parameter logic [fr_pkg::DATA_W-1:0] UNLK_DATA2 = 8'h55,
    parameter logic [fr_pkg::DATA_W-1:0] PROG_CMD   = 8'ha0,
    parameter logic [fr_pkg::DATA_W-1:0] ERASE_CMD  = 8'h80,
    parameter logic [fr_pkg::DATA_W-1:0] SECT_CMD   = 8'h30
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // User command
    input  wire logic                      cmd_valid,
    input  wire fr_pkg::fr_op_t            cmd_op,
    input  wire logic [fr_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [fr_pkg::DATA_W-1:0] cmd_data,
    // User answer
    output logic                           busy,
    output logic                           done,
    output logic                           err,
    output logic      [fr_pkg::DATA_W-1:0] rd_data,
    // Flash pins
    output logic                           flash_reset_n,
    output logic                           flash_vid_en,
    output logic                           flash_ce_n,
    output logic                           flash_we_n,
    output logic                           flash_oe_n,
    output logic      [fr_pkg::ADDR_W-1:0] flash_addr,
    output logic      [fr_pkg::DATA_W-1:0] flash_dq_o,
    output logic                           flash_dq_oe_n,
    input  wire logic [fr_pkg::DATA_W-1:0] flash_dq_i,
    input  wire logic                      ready_busy_out_n
);
    import fr_pkg::*;

    typedef enum {ST_IDLE, ST_SEQ, ST_POLL, ST_RST_LOW, ST_WAIT} fr_state_t;

    fr_state_t          state_r;
    fr_op_t             op_r;
    logic [ADDR_W-1:0]  addr_r;
    logic [DATA_W-1:0]  data_r;
    logic [2:0]         step_r;
    logic [TMR_W-1:0]   tmr_r;
    logic               emb_r;
    logic               tl_again_r;
    logic               poll_first_r;
    logic               err_pend_r;
    logic [DATA_W-1:0]  stat_a_r;
    logic               cyc_start_r;
    logic               cyc_wr_r;
    logic [ADDR_W-1:0]  cyc_addr_r;
    logic [DATA_W-1:0]  cyc_data_r;
    logic               cyc_done;
    logic [DATA_W-1:0]  cyc_rdata;

    function automatic logic [ADDR_W-1:0] seq_addr(input fr_op_t op, input logic [2:0] s,
                                                   input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] r;
        r = a;
        if (op == OP_PROGRAM || op == OP_ERASE) begin
            case (s)
                3'h0, 3'h2, 3'h3: r = (op == OP_PROGRAM && s == 3'h3) ? a : UNLK_ADDR1;
                3'h1, 3'h4: r = UNLK_ADDR2;
                default: r = a;
            endcase
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] seq_data(input fr_op_t op, input logic [2:0] s,
                                                   input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = d;
        if (op == OP_PROGRAM || op == OP_ERASE) begin
            case (s)
                3'h0: r = UNLK_DATA1;
                3'h1: r = UNLK_DATA2;
                3'h2: r = (op == OP_PROGRAM) ? PROG_CMD : ERASE_CMD;
                3'h3: r = (op == OP_PROGRAM) ? d : UNLK_DATA1;
                3'h4: r = UNLK_DATA2;
                default: r = SECT_CMD;
            endcase
        end
        return r;
    endfunction

    // Decode of the current sequence and of the status pair
    wire [2:0] last_step  = (op_r == OP_ERASE) ? LAST_ERASE :
                            (op_r == OP_PROGRAM) ? LAST_PROG : 3'h0;
    wire       seq_last   = (step_r == last_step);
    wire [2:0] step_next  = step_r + 3'h1;
    wire       toggling   = stat_a_r[BIT_BUSY_TOGGLE] ^ cyc_rdata[BIT_BUSY_TOGGLE];
    wire       tl_set     = cyc_rdata[BIT_TIME_LIMIT];
    wire       tmr_zero   = (tmr_r == '0);
    wire       poll_end   = (state_r == ST_POLL) && cyc_done && !poll_first_r;
    wire       poll_ok    = poll_end && !toggling && ready_busy_out_n;
    wire       poll_fail  = poll_end && toggling && tl_set && tl_again_r;
    wire       is_seq_op  = (cmd_op == OP_READ) || (cmd_op == OP_WRITE) ||
                            (cmd_op == OP_PROGRAM) || (cmd_op == OP_ERASE);

    always_ff @(posedge clk) begin
        done        <= 1'b0;
        cyc_start_r <= 1'b0;
        if (!reset_n) begin
            state_r       <= ST_IDLE;
            op_r          <= OP_READ;
            addr_r        <= '0;
            data_r        <= '0;
            step_r        <= 3'h0;
            tmr_r         <= '0;
            emb_r         <= 1'b0;
            tl_again_r    <= 1'b0;
            poll_first_r  <= 1'b0;
            err_pend_r    <= 1'b0;
            stat_a_r      <= '0;
            cyc_wr_r      <= 1'b0;
            cyc_addr_r    <= '0;
            cyc_data_r    <= '0;
            busy          <= 1'b0;
            err           <= 1'b0;
            rd_data       <= '0;
            flash_reset_n <= 1'b1;
            flash_vid_en  <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        busy   <= 1'b1;
                        op_r   <= cmd_op;
                        addr_r <= cmd_addr;
                        data_r <= cmd_data;
                        err    <= 1'b0;
                        step_r <= 3'h0;
                        if (!flash_reset_n) begin
                            // Out of standby every command only wakes the flash and is not itself run
                            flash_reset_n <= 1'b1;
                            tmr_r         <= TMR_W'(RH_CYC - 1);
                            state_r       <= ST_WAIT;
                        end else if (is_seq_op) begin
                            cyc_start_r <= 1'b1;
                            cyc_wr_r    <= (cmd_op != OP_READ);
                            cyc_addr_r  <= seq_addr(cmd_op, 3'h0, cmd_addr);
                            cyc_data_r  <= seq_data(cmd_op, 3'h0, cmd_data);
                            state_r     <= ST_SEQ;
                        end else if (cmd_op == OP_RESET || cmd_op == OP_STANDBY) begin
                            flash_reset_n <= 1'b0;
                            tmr_r         <= TMR_W'(RP_CYC - 1);
                            state_r       <= ST_RST_LOW;
                        end else begin
                            flash_vid_en <= (cmd_op == OP_UNPROT_ON);
                            // Elevated level settles before any command write
                            tmr_r        <= (cmd_op == OP_UNPROT_ON) ? TMR_W'(RSP_CYC - 1)
                                                                     : TMR_W'(VIDR_CYC - 1);
                            state_r      <= ST_WAIT;
                        end
                    end
                end
                ST_SEQ: begin
                    if (cyc_done) begin
                        if (op_r == OP_READ || op_r == OP_WRITE) begin
                            rd_data <= cyc_rdata;
                            busy    <= 1'b0;
                            done    <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (seq_last) begin
                            // Status reads stay at the target address, inside the sector
                            emb_r        <= 1'b1;
                            poll_first_r <= 1'b1;
                            cyc_start_r  <= 1'b1;
                            cyc_wr_r     <= 1'b0;
                            cyc_addr_r   <= addr_r;
                            state_r      <= ST_POLL;
                        end else begin
                            step_r      <= step_next;
                            cyc_start_r <= 1'b1;
                            cyc_addr_r  <= seq_addr(op_r, step_next, addr_r);
                            cyc_data_r  <= seq_data(op_r, step_next, data_r);
                        end
                    end
                end
                ST_POLL: begin
                    // No fixed wait: two status reads per round, compared on the toggle bit only
                    if (cyc_done) begin
                        if (poll_first_r) begin
                            stat_a_r     <= cyc_rdata;
                            poll_first_r <= 1'b0;
                            cyc_start_r  <= 1'b1;
                        end else if (poll_ok) begin
                            emb_r   <= 1'b0;
                            rd_data <= cyc_rdata;
                            busy    <= 1'b0;
                            done    <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (poll_fail) begin
                            // Still toggling after the flag: abort with a hardware reset
                            err_pend_r    <= 1'b1;
                            rd_data       <= cyc_rdata;
                            flash_reset_n <= 1'b0;
                            tmr_r         <= TMR_W'(RP_CYC - 1);
                            state_r       <= ST_RST_LOW;
                        end else begin
                            // A flag seen while toggling earns one more round before failing
                            tl_again_r   <= tl_again_r | (toggling & tl_set);
                            poll_first_r <= 1'b1;
                            cyc_start_r  <= 1'b1;
                        end
                    end
                end
                ST_RST_LOW: begin
                    if (!tmr_zero) begin
                        tmr_r <= tmr_r - TMR_W'(1);
                    end else if (op_r == OP_STANDBY && !err_pend_r) begin
                        // Pin stays low; standby lasts until the next command
                        busy    <= 1'b0;
                        done    <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        flash_reset_n <= 1'b1;
                        emb_r         <= 1'b0;
                        tmr_r         <= emb_r ? TMR_W'(REL_EMB_CYC - 1)
                                               : TMR_W'(REL_CYC - 1);
                        state_r       <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!tmr_zero) begin
                        tmr_r <= tmr_r - TMR_W'(1);
                    end else begin
                        err        <= err_pend_r;
                        err_pend_r <= 1'b0;
                        tl_again_r <= 1'b0;
                        busy       <= 1'b0;
                        done       <= 1'b1;
                        state_r    <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    fr_cycle u_cycle (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (cyc_start_r),
        .wr      (cyc_wr_r),
        .addr    (cyc_addr_r),
        .wdata   (cyc_data_r),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .ce_n    (flash_ce_n),
        .we_n    (flash_we_n),
        .oe_n    (flash_oe_n),
        .addr_o  (flash_addr),
        .dq_o    (flash_dq_o),
        .dq_oe_n (flash_dq_oe_n),
        .dq_i    (flash_dq_i)
    );

    // Helper counters watched only by the assertions below
    logic [TMR_W-1:0] low_cnt_r;
    logic [TMR_W-1:0] high_cnt_r;
    logic [TMR_W-1:0] fall_cnt_r;
    logic [TMR_W-1:0] vid_cnt_r;
    logic             emb_fall_r;
    logic             rst_pin_d_r;

    wire [TMR_W-1:0] cnt_max = '1;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            low_cnt_r   <= '0;
            high_cnt_r  <= '1;
            fall_cnt_r  <= '1;
            vid_cnt_r   <= '0;
            emb_fall_r  <= 1'b0;
            rst_pin_d_r <= 1'b1;
        end else begin
            rst_pin_d_r <= flash_reset_n;
            low_cnt_r   <= flash_reset_n ? '0 : low_cnt_r + TMR_W'(low_cnt_r != cnt_max);
            high_cnt_r  <= !flash_reset_n ? '0 : high_cnt_r + TMR_W'(high_cnt_r != cnt_max);
            vid_cnt_r   <= !flash_vid_en ? '0 : vid_cnt_r + TMR_W'(vid_cnt_r != cnt_max);
            if (rst_pin_d_r && !flash_reset_n) begin
                fall_cnt_r <= '0;
                emb_fall_r <= emb_r;
            end else begin
                fall_cnt_r <= fall_cnt_r + TMR_W'(fall_cnt_r != cnt_max);
            end
        end
    end

    a_rst_pulse_w: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(flash_reset_n) |-> low_cnt_r >= RP_CYC)
        else $error("reset pulse shorter than its minimum");

    a_emb_ready: assert property (@(posedge clk) disable iff (!reset_n)
        ($fell(flash_ce_n) && emb_fall_r) |-> fall_cnt_r >= READY_EMB_CYC)
        else $error("access too soon after reset that aborted an operation");

    a_idle_ready: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(flash_ce_n) |-> fall_cnt_r >= READY_CYC)
        else $error("access too soon after reset");

    a_rh_before_rd: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(flash_oe_n) |-> flash_reset_n && high_cnt_r >= RH_CYC)
        else $error("read started too soon after reset release");

    a_vid_setup: assert property (@(posedge clk) disable iff (!reset_n)
        ($fell(flash_we_n) && flash_vid_en) |-> vid_cnt_r >= RSP_CYC)
        else $error("write too soon after elevated reset level");

    a_poll_addr: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == ST_POLL && !flash_oe_n) |-> flash_addr == addr_r)
        else $error("status read outside the target address");

    a_poll_pair: assert property (@(posedge clk) disable iff (!reset_n)
        (done && !err && $past(state_r) == ST_POLL && (op_r == OP_PROGRAM || op_r == OP_ERASE))
            |-> rd_data[BIT_BUSY_TOGGLE] == stat_a_r[BIT_BUSY_TOGGLE])
        else $error("completion reported while toggle bit still flips");

    a_fail_reset: assert property (@(posedge clk) disable iff (!reset_n)
        poll_fail |=> !flash_reset_n && state_r == ST_RST_LOW)
        else $error("time-limit failure not followed by reset");

endmodule
`default_nettype wire

// >>> test/fr_flash_model.sv
/*
 Cycle model of the parallel flash seen by the controller.
 Assumes pins are synchronous to clk; stuck forces a program that never ends.
*/
`timescale 1ns/10ps
`default_nettype none
module fr_flash_model #(parameter int BUSY_CYC = 300) (
    // Clock and test control
    input  wire logic       clk,
    input  wire logic       stuck,
    // Flash pins
    input  wire logic       rst_pin_n,
    input  wire logic       ce_n,
    input  wire logic       we_n,
    input  wire logic       oe_n,
    input  wire logic [7:0] dq,
    input  wire logic       dq_oe_n,
    output logic      [7:0] dq_i,
    output logic            ready_busy_out_n
);
    logic [15:0] bcnt_r;
    logic [2:0]  wcnt_r;
    logic [7:0]  cmd3_r;
    logic        we_q_r;
    logic        oe_q_r;
    logic        tog_r;
    logic [7:0]  val;
    // Starts idle and ready; strobe copies start at the pins' idle level, so no false edge
    initial {bcnt_r, wcnt_r, cmd3_r, tog_r} = '0;
    initial {we_q_r, oe_q_r} = 2'b11;
    // Released bus shows the inverse so a stale value never passes
    assign val = (bcnt_r != 0) ? {1'b0, tog_r, stuck, 5'h00} : 8'h3c;
    assign dq_i = (oe_n || ce_n) ? ~val : val;
    assign ready_busy_out_n = (bcnt_r == 0);
    always @(posedge clk) begin
        we_q_r <= we_n;
        oe_q_r <= oe_n;
        if (!rst_pin_n) begin
            bcnt_r <= 0;
            wcnt_r <= 0;
        end else begin
            if (bcnt_r != 0 && !stuck) bcnt_r <= bcnt_r - 1;
            if (we_n && !we_q_r && !ce_n) begin
                wcnt_r <= wcnt_r + 1;
                // A command byte only counts while the controller drives the bus
                if (wcnt_r == 2) cmd3_r <= dq_oe_n ? 8'h00 : dq;
                if ((wcnt_r == 3 && cmd3_r == 8'ha0) || wcnt_r == 5) begin
                    // Erase zero-fills its sector first, so it stays busy longer
                    bcnt_r <= (wcnt_r == 5) ? 16'(2 * BUSY_CYC) : 16'(BUSY_CYC);
                    wcnt_r <= 0;
                end
            end
            if (!oe_n && oe_q_r && !ce_n) tog_r <= ~tog_r;
        end
    end
endmodule
`default_nettype wire

// >>> test/fr_ctrl_bench.sv
/*
 Self-checking bench for fr_ctrl against the flash model.
 Assumes the flash model answers within a few hundred cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module fr_ctrl_bench;
    import fr_pkg::*;
    logic clk = 0, reset_n = 0, cmd_valid = 0, stuck = 0, rst_seen = 0;
    fr_op_t cmd_op = OP_READ;
    logic [19:0] cmd_addr = 20'h00100, f_addr;
    logic [7:0] cmd_data = 8'h5a, rd_data, dq_o, dq_i;
    logic busy, done, err, f_rst_n, vid, ce_n, we_n, oe_n, dq_oe_n, rdy_n;
    int bad_count = 0, tests_run = 0;
    always #5 clk = ~clk;
    // Set by any reset pulse on the pin, cleared when a new command is taken
    always @(posedge clk) rst_seen <= !f_rst_n || (rst_seen && !cmd_valid);
    fr_ctrl DUT (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy), .done(done), .err(err),
        .rd_data(rd_data), .flash_reset_n(f_rst_n), .flash_vid_en(vid), .flash_ce_n(ce_n),
        .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(f_addr), .flash_dq_o(dq_o),
        .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i), .ready_busy_out_n(rdy_n));
    fr_flash_model FLASH (.clk(clk), .stuck(stuck), .rst_pin_n(f_rst_n), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .dq(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i),
        .ready_busy_out_n(rdy_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_cmd(input fr_op_t op);
        int n;
        @(posedge clk);
        cmd_op <= op;
        cmd_valid <= 1;
        @(posedge clk);
        cmd_valid <= 0;
        for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge clk) #1;
        check({7'h0, done}, 8'h01);
        check({7'h0, busy}, 8'h00);
    endtask
    task automatic t_read;
        do_cmd(OP_READ);
        check(rd_data, 8'h3c);
    endtask
    task automatic t_prog(input logic stk);
        stuck <= stk;
        do_cmd(OP_PROGRAM);
        stuck <= 0;
        check({7'h0, err}, {7'h0, stk});
        check({7'h0, rst_seen}, {7'h0, stk});
        check({7'h0, rdy_n}, 8'h01);
        check({7'h0, f_addr == cmd_addr}, 8'h01);
        if (!stk) check(rd_data, 8'h3c);
        t_read();
    endtask
    task automatic t_erase;
        do_cmd(OP_ERASE);
        check({7'h0, err}, 8'h00);
        check({7'h0, f_addr == cmd_addr}, 8'h01);
        check(rd_data, 8'h3c);
    endtask
    task automatic t_pins;
        do_cmd(OP_RESET);
        t_read();
        do_cmd(OP_UNPROT_ON);
        check({7'h0, vid}, 8'h01);
        do_cmd(OP_WRITE);
        do_cmd(OP_UNPROT_OFF);
        check({7'h0, vid}, 8'h00);
        do_cmd(OP_STANDBY);
        repeat (READY_EMB_CYC) @(posedge clk);
        check({7'h0, f_rst_n}, 8'h00);
        do_cmd(OP_READ);
        check({7'h0, f_rst_n}, 8'h01);
        t_read();
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1;
        t_read();
        t_prog(0);
        t_prog(1);
        t_erase();
        t_pins();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
